// ===== irq_flag_reg.sv
// one byte of sticky interrupt flags, set by the usb core, cleared by a read.
// assumes set and clear come from logic on sys_clk.
`timescale 1ns/1ns
module irq_flag_reg (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [7:0] setMask,
   input wire logic clearReq,
   output logic [7:0] flags
);
   // a set arriving in the clearing cycle survives
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         flags <= usb_ixp_pkg::REG_RESET;
      end else if (clearReq) begin
         flags <= setMask;
      end else begin
         flags <= flags | setMask;
      end
   end
endmodule : irq_flag_reg

// ===== usb_indirect_register_port.sv
// indirect sfr window onto the usb core register map.
// assumes sfr strobes, core status inputs and fifo data all run on sys_clk.
`timescale 1ns/1ns
module usb_indirect_register_port (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [7:0] sfrAddr,
   input wire logic [7:0] sfrWrData,
   input wire logic sfrWrite,
   input wire logic sfrRead,
   output logic [7:0] sfrRdData,
   input wire logic [7:0] inIrqSet,
   input wire logic [7:0] outIrqSet,
   input wire logic [7:0] commonIrqSet,
   input wire logic [10:0] frameNumber,
   input wire logic [7:0] ep0RxCount,
   input wire logic [7:0] outCountLow,
   input wire logic [7:0] outCountHigh,
   input wire logic [7:0] fifoRdData,
   output logic fifoRead,
   output logic fifoWrite,
   output logic [1:0] fifoSel,
   output logic [7:0] fifoWrData,
   output logic [7:0] functionAddress,
   output logic [7:0] powerControl,
   output logic [7:0] inIrqEnable,
   output logic [7:0] outIrqEnable,
   output logic [7:0] commonIrqEnable,
   output logic [3:0] endpointIndex,
   output logic [7:0] clockRecovery,
   output logic [7:0] inIrqFlags,
   output logic [7:0] outIrqFlags,
   output logic [7:0] commonIrqFlags
);
   logic busy;
   logic autoRead;
   logic isWrite;
   logic [1:0] cnt;
   logic [5:0] targetIndex;
   logic [7:0] dataWindow;
   logic [7:0] readValue;
   logic [7:0] ep0Control;
   logic [7:0] inCsrLow [0:3];
   logic [7:0] inCsrHigh [0:3];
   logic [7:0] outCsrLow [0:3];
   logic [7:0] outCsrHigh [0:3];
   logic addrWr;
   logic dataWr;
   logic dataRd;
   logic startRd;
   logic startWr;
   logic commit;
   logic commitWr;
   logic commitRd;
   logic ep0Sel;
   logic [1:0] ep;
   logic fifoIdx;
   logic epBacked;
   logic [2:0] busyRun;

   assign addrWr = sfrWrite && (sfrAddr == usb_ixp_pkg::SFR_ADDRESS_REG);
   assign dataWr = sfrWrite && (sfrAddr == usb_ixp_pkg::SFR_DATA_WINDOW);
   assign dataRd = sfrRead && (sfrAddr == usb_ixp_pkg::SFR_DATA_WINDOW);
   // access starts and address writes while busy are dropped; software is expected to poll first
   assign startRd = !busy && ((addrWr && sfrWrData[usb_ixp_pkg::BUSY_BIT])
                    || (dataRd && autoRead));
   assign startWr = !busy && dataWr;
   assign commit = busy && (cnt == 2'h1);
   assign commitWr = commit && isWrite;
   assign commitRd = commit && !isWrite;
   assign ep0Sel = (endpointIndex == 4'h0);
   assign ep = endpointIndex[1:0];
   // only endpoints zero to three have control and status storage
   assign epBacked = (endpointIndex[3:2] == 2'h0);
   assign fifoIdx = (targetIndex[5:2] == usb_ixp_pkg::IDX_FIFO_GROUP);
   assign fifoSel = targetIndex[1:0];
   assign fifoWrData = dataWindow;
   assign fifoWrite = commitWr && fifoIdx;
   // fifo byte is requested early so it is ready when the access completes
   assign fifoRead = busy && !isWrite && fifoIdx && (cnt == usb_ixp_pkg::ACCESS_CYCLES);

   // index and auto-read flag; busy keeps them frozen
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         targetIndex <= 6'h00;
         autoRead <= 1'b0;
      end else if (addrWr && !busy) begin
         targetIndex <= sfrWrData[5:0];
         autoRead <= sfrWrData[usb_ixp_pkg::AUTO_READ_BIT];
      end
   end

   // access sequencer
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         busy <= 1'b0;
         isWrite <= 1'b0;
         cnt <= 2'h0;
      end else if (startRd || startWr) begin
         busy <= 1'b1;
         isWrite <= startWr;
         cnt <= usb_ixp_pkg::ACCESS_CYCLES;
      end else if (commit) begin
         busy <= 1'b0;
         cnt <= 2'h0;
      end else if (busy) begin
         cnt <= cnt - 2'h1;
      end
   end

   // data window: software write, or read result once fetched
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         dataWindow <= usb_ixp_pkg::DATA_WINDOW_RESET;
      end else if (startWr) begin
         dataWindow <= sfrWrData;
      end else if (commitRd) begin
         dataWindow <= readValue;
      end
   end

   // sfr read data, registered one cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         sfrRdData <= 8'h00;
      end else if (sfrRead) begin
         if (sfrAddr == usb_ixp_pkg::SFR_ADDRESS_REG) begin
            sfrRdData <= {busy, autoRead, targetIndex};
         end else if (sfrAddr == usb_ixp_pkg::SFR_DATA_WINDOW) begin
            sfrRdData <= dataWindow;
         end else begin
            sfrRdData <= 8'h00;
         end
      end
   end

   // core register read decode
   always_comb begin
      readValue = 8'h00;
      case (targetIndex)
         usb_ixp_pkg::IDX_FUNCTION_ADDRESS: readValue = functionAddress;
         usb_ixp_pkg::IDX_POWER_MANAGEMENT: readValue = powerControl;
         usb_ixp_pkg::IDX_IN_IRQ_FLAGS: readValue = inIrqFlags;
         usb_ixp_pkg::IDX_OUT_IRQ_FLAGS: readValue = outIrqFlags;
         usb_ixp_pkg::IDX_COMMON_IRQ_FLAGS: readValue = commonIrqFlags;
         usb_ixp_pkg::IDX_IN_IRQ_ENABLES: readValue = inIrqEnable;
         usb_ixp_pkg::IDX_OUT_IRQ_ENABLES: readValue = outIrqEnable;
         usb_ixp_pkg::IDX_COMMON_IRQ_ENABLES: readValue = commonIrqEnable;
         usb_ixp_pkg::IDX_FRAME_LOW: readValue = frameNumber[7:0];
         usb_ixp_pkg::IDX_FRAME_HIGH: readValue = {5'h00, frameNumber[10:8]};
         usb_ixp_pkg::IDX_ENDPOINT_SELECT: readValue = {4'h0, endpointIndex};
         usb_ixp_pkg::IDX_CLOCK_RECOVERY: readValue = clockRecovery;
         usb_ixp_pkg::IDX_EP0_CONTROL: readValue = ep0Sel ? ep0Control : inCsrLow[ep];
         usb_ixp_pkg::IDX_IN_CSR_HIGH: readValue = inCsrHigh[ep];
         usb_ixp_pkg::IDX_OUT_CSR_LOW: readValue = outCsrLow[ep];
         usb_ixp_pkg::IDX_OUT_CSR_HIGH: readValue = outCsrHigh[ep];
         usb_ixp_pkg::IDX_EP0_COUNT: readValue = ep0Sel ? ep0RxCount : outCountLow;
         usb_ixp_pkg::IDX_OUT_COUNT_HIGH: readValue = outCountHigh;
         default: readValue = fifoIdx ? fifoRdData : 8'h00;
      endcase
      // slots above endpoint three read zero rather than alias onto a lower one
      if (!epBacked) begin
         case (targetIndex)
            usb_ixp_pkg::IDX_EP0_CONTROL,
            usb_ixp_pkg::IDX_IN_CSR_HIGH,
            usb_ixp_pkg::IDX_OUT_CSR_LOW,
            usb_ixp_pkg::IDX_OUT_CSR_HIGH: readValue = 8'h00;
            default: ;
         endcase
      end
   end

   // common registers written through the window
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         functionAddress <= usb_ixp_pkg::REG_RESET;
         powerControl <= usb_ixp_pkg::REG_RESET;
         inIrqEnable <= usb_ixp_pkg::REG_RESET;
         outIrqEnable <= usb_ixp_pkg::REG_RESET;
         commonIrqEnable <= usb_ixp_pkg::REG_RESET;
         endpointIndex <= 4'h0;
         clockRecovery <= usb_ixp_pkg::CLOCK_RECOVERY_RESET;
      end else if (commitWr) begin
         case (targetIndex)
            usb_ixp_pkg::IDX_FUNCTION_ADDRESS: functionAddress <= dataWindow;
            usb_ixp_pkg::IDX_POWER_MANAGEMENT: powerControl <= dataWindow;
            usb_ixp_pkg::IDX_IN_IRQ_ENABLES: inIrqEnable <= dataWindow;
            usb_ixp_pkg::IDX_OUT_IRQ_ENABLES: outIrqEnable <= dataWindow;
            usb_ixp_pkg::IDX_COMMON_IRQ_ENABLES: commonIrqEnable <= dataWindow;
            usb_ixp_pkg::IDX_ENDPOINT_SELECT: endpointIndex <= dataWindow[3:0];
            usb_ixp_pkg::IDX_CLOCK_RECOVERY: clockRecovery <= dataWindow;
            default: ;
         endcase
      end
   end

   // indexed registers; endpoints above three are not backed and read as zero
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ep0Control <= usb_ixp_pkg::REG_RESET;
         for (int i = 0; i < 4; i++) begin
            inCsrLow[i] <= usb_ixp_pkg::REG_RESET;
            inCsrHigh[i] <= usb_ixp_pkg::REG_RESET;
            outCsrLow[i] <= usb_ixp_pkg::REG_RESET;
            outCsrHigh[i] <= usb_ixp_pkg::REG_RESET;
         end
      end else if (commitWr && epBacked) begin
         case (targetIndex)
            usb_ixp_pkg::IDX_EP0_CONTROL: begin
               if (ep0Sel) begin
                  ep0Control <= dataWindow;
               end else begin
                  inCsrLow[ep] <= dataWindow;
               end
            end
            usb_ixp_pkg::IDX_IN_CSR_HIGH: inCsrHigh[ep] <= dataWindow;
            usb_ixp_pkg::IDX_OUT_CSR_LOW: outCsrLow[ep] <= dataWindow;
            usb_ixp_pkg::IDX_OUT_CSR_HIGH: outCsrHigh[ep] <= dataWindow;
            default: ;
         endcase
      end
   end

   // flags clear when read through the window
   irq_flag_reg inFlagReg (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .setMask(inIrqSet),
      .clearReq(commitRd && (targetIndex == usb_ixp_pkg::IDX_IN_IRQ_FLAGS)),
      .flags(inIrqFlags)
   );
   irq_flag_reg outFlagReg (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .setMask(outIrqSet),
      .clearReq(commitRd && (targetIndex == usb_ixp_pkg::IDX_OUT_IRQ_FLAGS)),
      .flags(outIrqFlags)
   );
   irq_flag_reg commonFlagReg (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .setMask(commonIrqSet),
      .clearReq(commitRd && (targetIndex == usb_ixp_pkg::IDX_COMMON_IRQ_FLAGS)),
      .flags(commonIrqFlags)
   );

   // run length of busy, kept only so the access time can be bounded
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         busyRun <= 3'h0;
      end else if (busy) begin
         busyRun <= busyRun + 3'h1;
      end else begin
         busyRun <= 3'h0;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   a_busy_read_hold: assert property (startRd |=> busy [*2] ##1 !busy)
      else $error("busy not held two cycles for read");
   a_window_write: assert property (startWr |=> dataWindow == $past(sfrWrData))
      else $error("data window did not take written byte");
   a_write_forward: assert property (startWr && targetIndex == 6'h00
      |-> ##3 functionAddress == $past(sfrWrData, 3))
      else $error("write not forwarded to function address");
   a_read_start: assert property (addrWr && !busy && sfrWrData[7] |=> busy && !isWrite)
      else $error("busy write did not start a read");
   a_in_enable: assert property (commitWr && targetIndex == 6'h07
      |=> inIrqEnable == $past(dataWindow))
      else $error("in enables not written");
   a_out_flag_set: assert property (outIrqSet[1] |=> outIrqFlags[1])
      else $error("out flag lost");
   a_common_read: assert property (commitRd && targetIndex == 6'h06
      |=> dataWindow == $past(commonIrqFlags))
      else $error("common flags not fetched");
   a_frame_low: assert property (startRd && !addrWr && targetIndex == 6'h0C
      |-> ##3 dataWindow == $past(frameNumber[7:0]))
      else $error("frame low byte not fetched");
   a_ep0_control: assert property (commitRd && targetIndex == 6'h11
      && endpointIndex == 4'h0 |=> dataWindow == $past(ep0Control))
      else $error("endpoint zero control not fetched");
   a_out_count_high: assert property (commitRd && targetIndex == 6'h17
      |=> dataWindow == $past(outCountHigh))
      else $error("out count high not fetched");
   // busy, refusal, reset, fetch and write-back checks
   a_write_busy_hold: assert property (startWr |=> busy [*2] ##1 !busy)
      else $error("busy not held two cycles for write");
   a_busy_bounded: assert property (busyRun <= {1'b0, usb_ixp_pkg::ACCESS_CYCLES})
      else $error("busy held longer than one access");
   a_index_frozen: assert property (addrWr && busy |=> $stable(targetIndex))
      else $error("index changed while busy");
   a_write_refused: assert property (dataWr && busy && isWrite |=> $stable(dataWindow))
      else $error("window changed by a refused write");
   a_autoread_start: assert property (dataRd && autoRead && !busy |=> busy && !isWrite)
      else $error("auto-read did not start a fetch");
   a_window_reset: assert property (disable iff (1'b0) !resetn |=> dataWindow == 8'h00)
      else $error("data window not cleared by reset");
   a_in_flag_read: assert property (commitRd
      && targetIndex == usb_ixp_pkg::IDX_IN_IRQ_FLAGS
      |=> dataWindow == $past(inIrqFlags))
      else $error("in flags not fetched");
   a_out_flag_read: assert property (commitRd
      && targetIndex == usb_ixp_pkg::IDX_OUT_IRQ_FLAGS
      |=> dataWindow == $past(outIrqFlags))
      else $error("out flags not fetched");
   a_out_enable: assert property (commitWr
      && targetIndex == usb_ixp_pkg::IDX_OUT_IRQ_ENABLES
      |=> outIrqEnable == $past(dataWindow))
      else $error("out enables not written");
   a_power_write: assert property (commitWr
      && targetIndex == usb_ixp_pkg::IDX_POWER_MANAGEMENT
      |=> powerControl == $past(dataWindow))
      else $error("power control not written");
   a_common_clear: assert property (commitRd
      && targetIndex == usb_ixp_pkg::IDX_COMMON_IRQ_FLAGS
      |=> commonIrqFlags == $past(commonIrqSet))
      else $error("common flags not cleared by read");
   a_frame_high: assert property (commitRd
      && targetIndex == usb_ixp_pkg::IDX_FRAME_HIGH
      |=> dataWindow == {5'h00, $past(frameNumber[10:8])})
      else $error("frame high byte not fetched");
   a_ep_select: assert property (commitWr
      && targetIndex == usb_ixp_pkg::IDX_ENDPOINT_SELECT
      |=> endpointIndex == $past(dataWindow[3:0]))
      else $error("endpoint index not written");
   a_in_csr_high: assert property (commitRd
      && targetIndex == usb_ixp_pkg::IDX_IN_CSR_HIGH && epBacked
      |=> dataWindow == $past(inCsrHigh[ep]))
      else $error("in control high not fetched");
   a_unbacked_zero: assert property (commitRd
      && targetIndex == usb_ixp_pkg::IDX_IN_CSR_HIGH && !epBacked
      |=> dataWindow == 8'h00)
      else $error("unbacked endpoint slot not zero");
   a_out_csr_low: assert property (commitRd
      && targetIndex == usb_ixp_pkg::IDX_OUT_CSR_LOW && epBacked
      |=> dataWindow == $past(outCsrLow[ep]))
      else $error("out control low not fetched");
   a_ep0_count: assert property (commitRd
      && targetIndex == usb_ixp_pkg::IDX_EP0_COUNT && ep0Sel
      |=> dataWindow == $past(ep0RxCount))
      else $error("endpoint zero count not fetched");
endmodule : usb_indirect_register_port

// ===== usb_indirect_register_port_tb_top.sv
// self-checking bench for the usb indirect register port.
// assumes sfr strobes are driven on the falling edge and a two-cycle busy time.
`timescale 1ns/1ns
module usb_indirect_register_port_tb_top;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] sfrAddr, sfrWrData, sfrRdData, inIrqSet, outIrqSet, commonIrqSet;
   logic [7:0] ep0RxCount, outCountLow, outCountHigh, fifoRdData, fifoWrData;
   logic [7:0] functionAddress, powerControl, inIrqEnable, outIrqEnable;
   logic [7:0] commonIrqEnable, clockRecovery, inIrqFlags, outIrqFlags, commonIrqFlags;
   logic sfrWrite, sfrRead, fifoRead, fifoWrite, rdTaken;
   logic [10:0] frameNumber;
   logic [1:0] fifoSel;
   logic [3:0] endpointIndex;
   logic [9:0] fifoSeen;
   logic [31:0] seed;
   logic [7:0] expQ[$];
   logic [7:0] mskQ[$];
   int num_errors = 0;
   int checked = 0;
   int fifoReads = 0;
   localparam logic [5:0] CFG_IDX [0:6] = '{6'h00, 6'h01, 6'h07, 6'h09, 6'h0B, 6'h0E, 6'h0F};
   localparam logic [5:0] EP_IDX [0:3] = '{6'h11, 6'h12, 6'h14, 6'h15};
   localparam logic [5:0] FLAG_IDX [0:2] = '{6'h02, 6'h04, 6'h06};

   usb_indirect_register_port dut_u (.sys_clk(sys_clk), .resetn(resetn), .sfrAddr(sfrAddr),
      .sfrWrData(sfrWrData), .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrRdData(sfrRdData),
      .inIrqSet(inIrqSet), .outIrqSet(outIrqSet), .commonIrqSet(commonIrqSet),
      .frameNumber(frameNumber), .ep0RxCount(ep0RxCount), .outCountLow(outCountLow),
      .outCountHigh(outCountHigh), .fifoRdData(fifoRdData), .fifoRead(fifoRead),
      .fifoWrite(fifoWrite), .fifoSel(fifoSel), .fifoWrData(fifoWrData),
      .functionAddress(functionAddress), .powerControl(powerControl),
      .inIrqEnable(inIrqEnable), .outIrqEnable(outIrqEnable),
      .commonIrqEnable(commonIrqEnable), .endpointIndex(endpointIndex),
      .clockRecovery(clockRecovery), .inIrqFlags(inIrqFlags), .outIrqFlags(outIrqFlags),
      .commonIrqFlags(commonIrqFlags));

   always #5 sys_clk = ~sys_clk;

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   function automatic logic [7:0] portOf(logic [5:0] i);
      case (i)
         6'h00: return functionAddress;
         6'h01: return powerControl;
         6'h07: return inIrqEnable;
         6'h09: return outIrqEnable;
         6'h0B: return commonIrqEnable;
         6'h0E: return {4'h0, endpointIndex};
         6'h02: return inIrqFlags;
         6'h04: return outIrqFlags;
         6'h06: return commonIrqFlags;
         default: return clockRecovery;
      endcase
   endfunction : portOf

   task automatic check(string what, logic [15:0] exp, logic [15:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic test_done();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : test_done

   // read results are noted here and judged half a cycle later, at the falling edge, by the monitor
   always @(posedge sys_clk) begin
      rdTaken <= sfrRead;
      if (fifoWrite === 1'b1) begin
         fifoSeen <= {fifoSel, fifoWrData};
      end
      if (fifoRead === 1'b1) begin
         fifoReads++;
      end
   end

   always @(negedge sys_clk) begin
      if (rdTaken === 1'b1 && expQ.size() > 0) begin
         if (mskQ[0] != 8'h00) begin
            check("sfrRdData", {8'h00, expQ[0] & mskQ[0]}, {8'h00, sfrRdData & mskQ[0]});
         end
         void'(expQ.pop_front());
         void'(mskQ.pop_front());
      end
   end

   task automatic sfrWr(logic [7:0] a, logic [7:0] d);
      sfrAddr = a;
      sfrWrData = d;
      sfrWrite = 1'b1;
      @(negedge sys_clk);
      sfrWrite = 1'b0;
   endtask : sfrWr

   // waits a falling edge first so a strobe is never lowered and raised in one step
   task automatic sfrRd(logic [7:0] a, logic [7:0] e, logic [7:0] m);
      @(negedge sys_clk);
      sfrAddr = a;
      sfrRead = 1'b1;
      expQ.push_back(e);
      mskQ.push_back(m);
      @(negedge sys_clk);
      sfrRead = 1'b0;
   endtask : sfrRd

   // polls busy right after a start; the first poll must see busy when chk is set
   task automatic waitIdle(bit chk);
      int n;
      sfrAddr = usb_ixp_pkg::SFR_ADDRESS_REG;
      sfrRead = 1'b1;
      for (n = 0; n < 8; n++) begin
         expQ.push_back((chk && n == 0) ? 8'h80 : 8'h00);
         mskQ.push_back((chk && n == 0) ? 8'h80 : 8'h00);
         @(negedge sys_clk);
         if (sfrRdData[7] === 1'b0 && n > 0) break;
      end
      sfrRead = 1'b0;
      if (n == 8) begin
         num_errors++;
         $display("CHECK FAILED busy expected 0 seen 1");
         test_done();
      end
   endtask : waitIdle

   task automatic rdInd(logic [5:0] i, logic [7:0] e);
      sfrWr(usb_ixp_pkg::SFR_ADDRESS_REG, {2'b10, i});
      waitIdle(1'b1);
      sfrRd(usb_ixp_pkg::SFR_DATA_WINDOW, e, 8'hFF);
   endtask : rdInd

   task automatic wrInd(logic [5:0] i, logic [7:0] d);
      sfrWr(usb_ixp_pkg::SFR_ADDRESS_REG, {2'b00, i});
      waitIdle(1'b0);
      sfrWr(usb_ixp_pkg::SFR_DATA_WINDOW, d);
      waitIdle(1'b1);
   endtask : wrInd

   initial begin
      logic [7:0] d, m1, m2;
      logic [10:0] fn;
      seed = 32'h171E2D08;
      {sfrAddr, sfrWrData, sfrWrite, sfrRead, inIrqSet, outIrqSet, commonIrqSet} = '0;
      {frameNumber, ep0RxCount, outCountLow, outCountHigh, fifoRdData} = '0;
      repeat (20) @(negedge sys_clk);
      resetn = 1'b1;
      check("clockRecovery", 16'h0009, {8'h00, clockRecovery});
      sfrRd(usb_ixp_pkg::SFR_DATA_WINDOW, 8'h00, 8'hFF);
      sfrRd(8'h55, 8'h00, 8'hFF);
      rdInd(6'h03, 8'h00);
      for (int i = 0; i < 7; i++) begin
         d = 8'(rnd());
         if (CFG_IDX[i] == 6'h0E) d = d & 8'h03;
         wrInd(CFG_IDX[i], d);
         check("config port", {8'h00, d}, {8'h00, portOf(CFG_IDX[i])});
         rdInd(CFG_IDX[i], d);
      end
      // two writes land while busy and must be dropped; index is not reloaded
      wrInd(6'h00, 8'h5A);
      sfrAddr = usb_ixp_pkg::SFR_DATA_WINDOW;
      sfrWrData = 8'hA5;
      sfrWrite = 1'b1;
      @(negedge sys_clk);
      sfrWrData = 8'h3C;
      @(negedge sys_clk);
      sfrAddr = usb_ixp_pkg::SFR_ADDRESS_REG;
      sfrWrData = 8'h01;
      @(negedge sys_clk);
      sfrWrite = 1'b0;
      waitIdle(1'b0);
      check("functionAddress", 16'h00A5, {8'h00, functionAddress});
      sfrRd(usb_ixp_pkg::SFR_ADDRESS_REG, 8'h00, 8'hFF);
      for (int k = 0; k < 3; k++) begin
         m1 = 8'(rnd());
         m2 = 8'(rnd());
         for (int p = 0; p < 2; p++) begin
            @(negedge sys_clk);
            {inIrqSet, outIrqSet, commonIrqSet} = {3{p ? m2 : m1}} & (24'hFF0000 >> (8 * k));
            @(negedge sys_clk);
            {inIrqSet, outIrqSet, commonIrqSet} = '0;
         end
         check("irq flags", {8'h00, m1 | m2}, {8'h00, portOf(FLAG_IDX[k])});
         rdInd(FLAG_IDX[k], m1 | m2);
         rdInd(FLAG_IDX[k], 8'h00);
      end
      fn = 11'(rnd());
      frameNumber = fn;
      rdInd(6'h0C, fn[7:0]);
      rdInd(6'h0D, {5'h00, fn[10:8]});
      // auto-read: a window read hands back the old byte and fetches again
      sfrWr(usb_ixp_pkg::SFR_ADDRESS_REG, {2'b01, 6'h0C});
      waitIdle(1'b0);
      sfrRd(usb_ixp_pkg::SFR_DATA_WINDOW, {5'h00, fn[10:8]}, 8'hFF);
      @(negedge sys_clk);
      waitIdle(1'b1);
      sfrRd(usb_ixp_pkg::SFR_DATA_WINDOW, fn[7:0], 8'hFF);
      @(negedge sys_clk);
      waitIdle(1'b1);
      for (int ep = 1; ep < 4; ep++) begin
         wrInd(6'h0E, ep[7:0]);
         for (int j = 0; j < 4; j++) wrInd(EP_IDX[j], {ep[1:0], EP_IDX[j]});
      end
      for (int ep = 3; ep > 0; ep--) begin
         wrInd(6'h0E, ep[7:0]);
         for (int j = 0; j < 4; j++) rdInd(EP_IDX[j], {ep[1:0], EP_IDX[j]});
      end
      {ep0RxCount, outCountLow, outCountHigh} = 24'(rnd());
      rdInd(6'h16, outCountLow);
      wrInd(6'h0E, 8'h00);
      rdInd(6'h16, ep0RxCount);
      wrInd(6'h11, d);
      rdInd(6'h11, d);
      rdInd(6'h17, outCountHigh);
      wrInd(6'h0E, 8'h05);
      rdInd(6'h12, 8'h00);
      fifoRdData = 8'(rnd());
      rdInd(6'h20, fifoRdData);
      check("fifoRead count", 16'h0001, fifoReads[15:0]);
      d = 8'(rnd());
      wrInd(6'h21, d);
      check("fifo write", {6'h00, 2'h1, d}, {6'h00, fifoSeen});
      test_done();
   end
endmodule : usb_indirect_register_port_tb_top

// ===== usb_ixp_pkg.sv
// constants for the usb indirect register port: sfr addresses, core indices,
// field positions, reset values and the access latency.
// assumes a single 100 MHz sys_clk domain shared with the usb core.
// How it works
// - data window at 0x97, resets to zero
// - busy holds until read data valid
// - index 0x02 in flags, 0x07 enables
// - index 0x04 out flags, 0x09 enables
// - index 0x06 common flags, 0x0B enables
// - frame number low 0x0C, high 0x0D
// - index 0x11 endpoint zero control, via 0x0E
// - index 0x12 in control high, indexed
// - indices 0x14/0x15 out control, indexed
// - index 0x16 endpoint zero received count, out count low for other endpoints
// - index 0x17 out count high, not indexed
package usb_ixp_pkg;
   localparam logic [7:0] SFR_ADDRESS_REG = 8'h96;
   localparam logic [7:0] SFR_DATA_WINDOW = 8'h97;
   localparam int BUSY_BIT = 7;
   localparam int AUTO_READ_BIT = 6;
   localparam logic [7:0] DATA_WINDOW_RESET = 8'h00;
   localparam logic [7:0] CLOCK_RECOVERY_RESET = 8'h09;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [5:0] IDX_FUNCTION_ADDRESS = 6'h00;
   localparam logic [5:0] IDX_POWER_MANAGEMENT = 6'h01;
   localparam logic [5:0] IDX_IN_IRQ_FLAGS = 6'h02;
   localparam logic [5:0] IDX_OUT_IRQ_FLAGS = 6'h04;
   localparam logic [5:0] IDX_COMMON_IRQ_FLAGS = 6'h06;
   localparam logic [5:0] IDX_IN_IRQ_ENABLES = 6'h07;
   localparam logic [5:0] IDX_OUT_IRQ_ENABLES = 6'h09;
   localparam logic [5:0] IDX_COMMON_IRQ_ENABLES = 6'h0B;
   localparam logic [5:0] IDX_FRAME_LOW = 6'h0C;
   localparam logic [5:0] IDX_FRAME_HIGH = 6'h0D;
   localparam logic [5:0] IDX_ENDPOINT_SELECT = 6'h0E;
   localparam logic [5:0] IDX_CLOCK_RECOVERY = 6'h0F;
   localparam logic [5:0] IDX_EP0_CONTROL = 6'h11;
   localparam logic [5:0] IDX_IN_CSR_HIGH = 6'h12;
   localparam logic [5:0] IDX_OUT_CSR_LOW = 6'h14;
   localparam logic [5:0] IDX_OUT_CSR_HIGH = 6'h15;
   localparam logic [5:0] IDX_EP0_COUNT = 6'h16;
   localparam logic [5:0] IDX_OUT_COUNT_HIGH = 6'h17;
   localparam logic [3:0] IDX_FIFO_GROUP = 4'h8;
   // busy stays up this many cycles per indirect access
   localparam logic [1:0] ACCESS_CYCLES = 2'h2;
endpackage : usb_ixp_pkg
